// file: aisa_top.sv
/*
 * Status, fault and process alarm logic of an analog input module, with an
 * APB register slave, sample timestamps and cold junction reporting.
 * Assumes the measurement datapath runs on core_clk and pulses sample_valid.
 */
// The implementer's own choices: the register offsets and the APB register port.
// What this block does
// - Every channel hard fault flag is gathered into one word, bit n for channel n.
// - A channel hard fault is set while calibrating, below range or above range.
// - The any-channel fault flag is the OR of all channel hard faults.
// - The input group fault flag is set while any input channel hard fault is set.
// - The calibrating flag is set while any channel is being calibrated.
// - A channel bad calibration flag shows its last calibration ended in error.
// - The module bad calibration flag is set when any channel has bad calibration.
// - The cold junction low flag is set while the reading is below 0.0 C.
// - The cold junction high flag is set while the reading is above 86.0 C.
// - A channel below range flag is set while its input is under range.
// - A channel above range flag is set while its input is over range.
// - The rate alarm sets above the rate limit and clears below it unless latched.
// - The low alarm sets below its trip and clears past deadband unless latched.
// - The high alarm sets above its trip and clears past deadband unless latched.
// - The low-low alarm works like the low alarm with its own trip point.
// - The high-high alarm works like the high alarm with its own trip point.
// - Each channel value is reported as a scaled engineering value.
// - The cold junction temperature is reported in Celsius or Fahrenheit.
// - With system time enabled, a 64 bit stamp is caught per sample as two words.
// - A module-local millisecond count is caught at each sample.
// - Each channel's flags are gathered into a per-channel status word.
module aisa_top
    import aisa_pkg::*;
#(
    parameter int MS_CYCLES_P = MS_CYCLES
) (
    // Clock, reset and clock enable.
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Measurement and calibration side.
    input wire logic sample_valid,
    input wire logic [NCH-1:0][31:0] meas_value,
    input wire logic [NCH-1:0] meas_below,
    input wire logic [NCH-1:0] meas_above,
    input wire logic [31:0] cj_celsius,
    input wire logic [NCH-1:0] cal_active,
    input wire logic [NCH-1:0] cal_done,
    input wire logic [NCH-1:0] cal_error,
    input wire logic [63:0] system_time,
    // Status outputs.
    output logic [NCH-1:0] chan_fault_word,
    output logic any_chan_fault,
    output logic any_input_fault,
    output logic calibrating,
    output logic any_bad_cal,
    output logic cold_junc_low,
    output logic cold_junc_high
);

    // Merges write data into a register under the byte strobes.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
            input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Next state of a process alarm with deadband and latching.
    function automatic logic proc_next(input logic cur, input logic low_side, input logic latch,
            input logic signed [31:0] v, input logic signed [31:0] trip,
            input logic signed [31:0] db);
        logic signed [33:0] vx;
        logic signed [33:0] edge_x;
        logic trip_now;
        logic clear_ok;
        vx = 34'(v);
        if (low_side) begin
            edge_x = 34'(trip) + 34'(db);
            trip_now = v < trip;
            clear_ok = vx > edge_x;
        end else begin
            edge_x = 34'(trip) - 34'(db);
            trip_now = v > trip;
            clear_ok = vx < edge_x;
        end
        return trip_now | (cur & ~(~latch & clear_ok));
    endfunction : proc_next

    // Next state of a rate alarm from the change since the previous sample.
    function automatic logic rate_next(input logic cur, input logic latch,
            input logic signed [31:0] v, input logic signed [31:0] prev,
            input logic signed [31:0] lim);
        logic signed [32:0] d;
        logic [32:0] mag;
        logic [32:0] limx;
        d = 33'(v) - 33'(prev);
        mag = d[32] ? 33'(-d) : 33'(d);
        limx = {1'b0, lim};
        return (mag > limx) | (cur & ~(~latch & (mag < limx)));
    endfunction : rate_next

    logic [1:0] ctrl;
    logic [1:0] cfg [NCH];
    logic signed [31:0] rate_limit_cfg [NCH];
    logic signed [31:0] alarm_deadband_cfg [NCH];
    logic signed [31:0] low_trip_cfg [NCH];
    logic signed [31:0] high_trip_cfg [NCH];
    logic signed [31:0] lowlow_trip_cfg [NCH];
    logic signed [31:0] highhigh_trip_cfg [NCH];
    logic signed [31:0] chan_value [NCH];
    logic signed [31:0] prev_value [NCH];
    logic [NCH-1:0] have_prev;
    logic [NCH-1:0] chan_below_range;
    logic [NCH-1:0] chan_above_range;
    logic [NCH-1:0] chan_bad_cal;
    logic [NCH-1:0] chan_rate_alarm;
    logic [NCH-1:0] chan_low_alarm;
    logic [NCH-1:0] chan_high_alarm;
    logic [NCH-1:0] chan_lowlow_alarm;
    logic [NCH-1:0] chan_highhigh_alarm;
    logic [7:0] chan_status_word [NCH];
    logic [4:0] unlatch [NCH];
    logic [NCH-1:0] next_fault;
    logic signed [31:0] cold_junc_temp;
    logic [63:0] system_time_stamp;
    logic [15:0] local_ms_stamp;
    logic [15:0] ms_count;
    logic [31:0] ms_div;
    logic [31:0] next_rdata;
    logic addr_ok;
    logic is_chan;
    logic [1:0] ch;
    logic [5:0] off;
    logic wr_en;
    logic signed [35:0] cj_times9;
    logic [31:0] module_fault_word;

    // APB decode; the slave answers with no wait states while enabled.
    assign is_chan = paddr[11:8] == A_CHAN_PAGE;
    assign ch = paddr[7:6];
    assign off = paddr[5:0];
    assign pready = ce;
    assign pslverr = psel & penable & ~addr_ok;
    assign wr_en = ce & psel & penable & pwrite & addr_ok;
    assign cj_times9 = 36'($signed(cj_celsius)) * 36'sh9;
    assign module_fault_word = {26'h0, cold_junc_high, cold_junc_low, any_bad_cal,
                                calibrating, any_input_fault, any_chan_fault};

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            chan_status_word[i] = {chan_highhigh_alarm[i], chan_lowlow_alarm[i],
                chan_high_alarm[i], chan_low_alarm[i], chan_rate_alarm[i],
                chan_above_range[i], chan_below_range[i], chan_bad_cal[i]};
            unlatch[i] = (wr_en && is_chan && ch == 2'(i) && off == O_UNLATCH) ?
                         pwdata[ST_HIGHHIGH:ST_RATE] : 5'h0;
        end
        next_fault = cal_active | chan_below_range | chan_above_range;
    end

    always_comb begin
        next_rdata = 32'h0;
        addr_ok = 1'b1;
        if (is_chan) begin
            case (off)
                O_STATUS: next_rdata = {24'h0, chan_status_word[ch]};
                O_VALUE: next_rdata = chan_value[ch];
                O_CFG: next_rdata = {30'h0, cfg[ch]};
                O_RATE: next_rdata = rate_limit_cfg[ch];
                O_DBAND: next_rdata = alarm_deadband_cfg[ch];
                O_LOW: next_rdata = low_trip_cfg[ch];
                O_HIGH: next_rdata = high_trip_cfg[ch];
                O_LOWLOW: next_rdata = lowlow_trip_cfg[ch];
                O_HIGHHIGH: next_rdata = highhigh_trip_cfg[ch];
                O_UNLATCH: next_rdata = 32'h0;
                default: addr_ok = 1'b0;
            endcase
        end else begin
            case (paddr)
                A_CHAN_FAULT: next_rdata = {{(32-NCH){1'b0}}, chan_fault_word};
                A_MOD_FAULT: next_rdata = module_fault_word;
                A_CTRL: next_rdata = {30'h0, ctrl};
                A_CJ_TEMP: next_rdata = cold_junc_temp;
                A_SYS_LO: next_rdata = system_time_stamp[31:0];
                A_SYS_HI: next_rdata = system_time_stamp[63:32];
                A_LOCAL_MS: next_rdata = {16'h0, local_ms_stamp};
                default: addr_ok = 1'b0;
            endcase
        end
    end

    // Read data is caught in the setup phase and held through the access.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h0;
        end else if (ce && psel && !penable && !pwrite) begin
            prdata <= next_rdata;
        end
    end

    // Configuration registers.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= CTRL_RST;
            for (int i = 0; i < NCH; i++) begin
                cfg[i] <= CFG_RST;
                rate_limit_cfg[i] <= RATE_RST;
                alarm_deadband_cfg[i] <= DBAND_RST;
                low_trip_cfg[i] <= LOW_RST;
                high_trip_cfg[i] <= HIGH_RST;
                lowlow_trip_cfg[i] <= LOW_RST;
                highhigh_trip_cfg[i] <= HIGH_RST;
            end
        end else if (wr_en) begin
            if (!is_chan && paddr == A_CTRL && pstrb[0]) begin
                ctrl <= pwdata[1:0];
            end
            if (is_chan) begin
                case (off)
                    O_CFG: cfg[ch] <= pstrb[0] ? pwdata[1:0] : cfg[ch];
                    O_RATE: rate_limit_cfg[ch] <= merge(rate_limit_cfg[ch], pwdata, pstrb);
                    O_DBAND: alarm_deadband_cfg[ch] <= merge(alarm_deadband_cfg[ch], pwdata, pstrb);
                    O_LOW: low_trip_cfg[ch] <= merge(low_trip_cfg[ch], pwdata, pstrb);
                    O_HIGH: high_trip_cfg[ch] <= merge(high_trip_cfg[ch], pwdata, pstrb);
                    O_LOWLOW: lowlow_trip_cfg[ch] <= merge(lowlow_trip_cfg[ch], pwdata, pstrb);
                    O_HIGHHIGH: highhigh_trip_cfg[ch] <= merge(highhigh_trip_cfg[ch], pwdata, pstrb);
                    default: ;
                endcase
            end
        end
    end

    // Per-sample channel values, range flags and alarms.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            have_prev <= '0;
            chan_below_range <= '0;
            chan_above_range <= '0;
            chan_rate_alarm <= '0;
            chan_low_alarm <= '0;
            chan_high_alarm <= '0;
            chan_lowlow_alarm <= '0;
            chan_highhigh_alarm <= '0;
            for (int i = 0; i < NCH; i++) begin
                chan_value[i] <= 32'sh0;
                prev_value[i] <= 32'sh0;
            end
        end else if (ce) begin
            for (int i = 0; i < NCH; i++) begin
                if (sample_valid) begin
                    chan_value[i] <= meas_value[i];
                    prev_value[i] <= meas_value[i];
                    have_prev[i] <= 1'b1;
                    chan_below_range[i] <= meas_below[i];
                    chan_above_range[i] <= meas_above[i];
                    chan_rate_alarm[i] <= have_prev[i] ? rate_next(chan_rate_alarm[i] & ~unlatch[i][0],
                        cfg[i][CF_RATE_LATCH], meas_value[i], prev_value[i],
                        rate_limit_cfg[i]) : 1'b0;
                    chan_low_alarm[i] <= proc_next(chan_low_alarm[i] & ~unlatch[i][1], 1'b1,
                        cfg[i][CF_PROC_LATCH], meas_value[i], low_trip_cfg[i],
                        alarm_deadband_cfg[i]);
                    chan_high_alarm[i] <= proc_next(chan_high_alarm[i] & ~unlatch[i][2], 1'b0,
                        cfg[i][CF_PROC_LATCH], meas_value[i], high_trip_cfg[i],
                        alarm_deadband_cfg[i]);
                    chan_lowlow_alarm[i] <= proc_next(chan_lowlow_alarm[i] & ~unlatch[i][3], 1'b1,
                        cfg[i][CF_PROC_LATCH], meas_value[i], lowlow_trip_cfg[i],
                        alarm_deadband_cfg[i]);
                    chan_highhigh_alarm[i] <= proc_next(chan_highhigh_alarm[i] & ~unlatch[i][4], 1'b0,
                        cfg[i][CF_PROC_LATCH], meas_value[i], highhigh_trip_cfg[i],
                        alarm_deadband_cfg[i]);
                end else begin
                    chan_rate_alarm[i] <= chan_rate_alarm[i] & ~unlatch[i][0];
                    chan_low_alarm[i] <= chan_low_alarm[i] & ~unlatch[i][1];
                    chan_high_alarm[i] <= chan_high_alarm[i] & ~unlatch[i][2];
                    chan_lowlow_alarm[i] <= chan_lowlow_alarm[i] & ~unlatch[i][3];
                    chan_highhigh_alarm[i] <= chan_highhigh_alarm[i] & ~unlatch[i][4];
                end
            end
        end
    end

    // Calibration results and fault summaries.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            chan_bad_cal <= '0;
            chan_fault_word <= '0;
            any_chan_fault <= 1'b0;
            any_input_fault <= 1'b0;
            calibrating <= 1'b0;
            any_bad_cal <= 1'b0;
        end else if (ce) begin
            for (int i = 0; i < NCH; i++) begin
                if (cal_done[i]) begin
                    chan_bad_cal[i] <= cal_error[i];
                end
            end
            chan_fault_word <= next_fault;
            any_chan_fault <= |next_fault;
            any_input_fault <= |next_fault;
            calibrating <= |cal_active;
            any_bad_cal <= |((chan_bad_cal & ~cal_done) | (cal_done & cal_error));
        end
    end

    // Cold junction reading and sample timestamps.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cold_junc_temp <= 32'sh0;
            cold_junc_low <= 1'b0;
            cold_junc_high <= 1'b0;
            system_time_stamp <= 64'h0;
            local_ms_stamp <= 16'h0;
        end else if (ce && sample_valid) begin
            cold_junc_low <= $signed(cj_celsius) < CJ_MIN_C;
            cold_junc_high <= $signed(cj_celsius) > CJ_MAX_C;
            cold_junc_temp <= ctrl[CT_TEMP_F] ? 32'(cj_times9 / 36'sh5) + F_OFFSET
                                              : $signed(cj_celsius);
            if (ctrl[CT_SYS_EN]) begin
                system_time_stamp <= system_time;
            end
            local_ms_stamp <= ms_count;
        end
    end

    // Free-running millisecond count local to the module.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ms_div <= 32'h0;
            ms_count <= 16'h0;
        end else if (ce) begin
            if (ms_div == 32'(MS_CYCLES_P - 1)) begin
                ms_div <= 32'h0;
                ms_count <= ms_count + 16'h1;
            end else begin
                ms_div <= ms_div + 32'h1;
            end
        end
    end

    AST_FAULT_WORD: assert property (@(posedge core_clk) disable iff (!rstn)
        (ce && sample_valid && meas_below[0]) ##1 ce |=> chan_fault_word[0])
        else $error("Channel fault not set after below range sample.");

    AST_ANY_FAULT: assert property (@(posedge core_clk) disable iff (!rstn)
        any_chan_fault == (|chan_fault_word))
        else $error("Any-channel fault differs from the fault word.");

    AST_INPUT_GROUP: assert property (@(posedge core_clk) disable iff (!rstn)
        (|chan_fault_word) |-> any_input_fault)
        else $error("Input group fault missing while a channel faults.");

    AST_CALIB: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && (|cal_active) |=> calibrating)
        else $error("Calibrating flag missing during calibration.");

    AST_BAD_CAL: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && cal_done[0] && cal_error[0] |=> chan_bad_cal[0] && any_bad_cal)
        else $error("Bad calibration not reported after failed calibration.");

    AST_CJ_HIGH: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && sample_valid && $signed(cj_celsius) > CJ_MAX_C |=> cold_junc_high && !cold_junc_low)
        else $error("Cold junction high flag not set.");

    AST_LOW_SET: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && sample_valid && $signed(meas_value[0]) < low_trip_cfg[0] |=> chan_low_alarm[0])
        else $error("Low alarm not set below its trip point.");

    AST_RATE_LATCH: assert property (@(posedge core_clk) disable iff (!rstn)
        chan_rate_alarm[0] && cfg[0][CF_RATE_LATCH] && unlatch[0][0] == 1'b0 |=> chan_rate_alarm[0])
        else $error("Latched rate alarm dropped without a release write.");

    AST_STAMP: assert property (@(posedge core_clk) disable iff (!rstn)
        ce && sample_valid |=> local_ms_stamp == $past(ms_count))
        else $error("Local millisecond stamp not caught at the sample.");

endmodule : aisa_top

// file: aisa_pkg.sv
/*
 * Shared constants of the analog input status and alarm block: register map,
 * field positions, reset values and timing counts.
 * Assumes a 250 MHz core clock and Q16.16 signed engineering values.
 */
package aisa_pkg;
    localparam int NCH = 4;
    localparam int CLK_NS = 4;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_NS;
    localparam logic signed [31:0] CJ_MIN_C = 32'sh0000_0000;
    localparam logic signed [31:0] CJ_MAX_C = 32'sh0056_0000;
    localparam logic signed [31:0] F_OFFSET = 32'sh0020_0000;
    localparam logic [11:0] A_CHAN_FAULT = 12'h000;
    localparam logic [11:0] A_MOD_FAULT = 12'h004;
    localparam logic [11:0] A_CTRL = 12'h008;
    localparam logic [11:0] A_CJ_TEMP = 12'h00c;
    localparam logic [11:0] A_SYS_LO = 12'h010;
    localparam logic [11:0] A_SYS_HI = 12'h014;
    localparam logic [11:0] A_LOCAL_MS = 12'h018;
    localparam logic [3:0] A_CHAN_PAGE = 4'h1;
    localparam logic [5:0] O_STATUS = 6'h00;
    localparam logic [5:0] O_VALUE = 6'h04;
    localparam logic [5:0] O_CFG = 6'h08;
    localparam logic [5:0] O_RATE = 6'h0c;
    localparam logic [5:0] O_DBAND = 6'h10;
    localparam logic [5:0] O_LOW = 6'h14;
    localparam logic [5:0] O_HIGH = 6'h18;
    localparam logic [5:0] O_LOWLOW = 6'h1c;
    localparam logic [5:0] O_HIGHHIGH = 6'h20;
    localparam logic [5:0] O_UNLATCH = 6'h24;
    localparam int ST_BAD_CAL = 0;
    localparam int ST_BELOW = 1;
    localparam int ST_ABOVE = 2;
    localparam int ST_RATE = 3;
    localparam int ST_LOW = 4;
    localparam int ST_HIGH = 5;
    localparam int ST_LOWLOW = 6;
    localparam int ST_HIGHHIGH = 7;
    localparam int CT_TEMP_F = 0;
    localparam int CT_SYS_EN = 1;
    localparam int CF_RATE_LATCH = 0;
    localparam int CF_PROC_LATCH = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [1:0] CFG_RST = 2'h0;
    localparam logic signed [31:0] LOW_RST = 32'sh8000_0000;
    localparam logic signed [31:0] HIGH_RST = 32'sh7fff_ffff;
    localparam logic signed [31:0] RATE_RST = 32'sh7fff_ffff;
    localparam logic signed [31:0] DBAND_RST = 32'sh0000_0000;
endpackage : aisa_pkg

// file: aisa_ctrl_model.sv
/*
 * Controller model: an APB master that reads the module's input data.
 * Assumes pready is sampled at rising edges of core_clk.
 */
module aisa_ctrl_model
    import aisa_pkg::*;
(
    // Clock and link state.
    input wire logic core_clk,
    input wire logic comm_lost,
    // APB master.
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Controller copy of the fault word.
    output logic [NCH-1:0] fault_copy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hung = 1'b0;
    logic [NCH-1:0] seen_faults = '0;
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hf;
    end
    // Lost communication forces every fault bit of the copy.
    assign fault_copy = comm_lost ? '1 : seen_faults;
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        hung = pready !== 1'b1;
        q = prdata;
        e = pslverr;
        if (!w && a == A_CHAN_FAULT) begin
            seen_faults = prdata[NCH-1:0];
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : aisa_ctrl_model

// file: aisa_top_tb.sv
/*
 * Self-checking bench of the status and alarm block, driven over APB.
 * Assumes zero wait states are not relied on and a 4 ns core clock.
 */
module aisa_top_tb
    import aisa_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rstn, ce, psel, penable, pwrite, pready, pslverr, sample_valid, comm_lost, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, cj_celsius, q, t0;
    logic [3:0] pstrb;
    logic [NCH-1:0][31:0] meas_value;
    logic [NCH-1:0] meas_below, meas_above, cal_active, cal_done, cal_error, chan_fault_word, fault_copy;
    logic [63:0] system_time;
    logic any_chan_fault, any_input_fault, calibrating, any_bad_cal, cold_junc_low, cold_junc_high;
    int errors = 0;
    int checks = 0;
    logic [11:0] ta[6] = '{12'h10c, 12'h110, 12'h114, 12'h118, 12'h11c, 12'h120};
    logic [31:0] tv[6] = '{32'h7fff_ffff, 32'h2_0000, 32'ha_0000, 32'h14_0000, 32'h5_0000, 32'h19_0000};
    logic [31:0] pv[8] = '{32'd9, 32'd12, 32'd13, 32'd21, 32'd18, 32'd17, 32'd4, 32'd26};
    logic [31:0] ps[8] = '{32'h10, 32'h10, 32'h0, 32'h20, 32'h20, 32'h0, 32'h50, 32'ha0};
    aisa_top #(.MS_CYCLES_P(10)) aisa_top_i (
        .core_clk, .rstn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .sample_valid, .meas_value, .meas_below, .meas_above, .cj_celsius, .cal_active,
        .cal_done, .cal_error, .system_time, .chan_fault_word, .any_chan_fault, .any_input_fault,
        .calibrating, .any_bad_cal, .cold_junc_low, .cold_junc_high
    );
    aisa_ctrl_model aisa_ctrl_model_i (.core_clk, .comm_lost, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .fault_copy);
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        aisa_ctrl_model_i.xfer(w, a, d, q, e);
        if (aisa_ctrl_model_i.hung) begin
            errors++;
            report_and_stop();
        end
    endtask : acc
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), q, exp);
    endtask : rd
    task automatic smp(input logic [31:0] v);
        @(posedge core_clk);
        meas_value[0] <= v;
        sample_valid <= 1'b1;
        @(posedge core_clk);
        sample_valid <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : smp
    initial begin
        {rstn, sample_valid, comm_lost, meas_below, meas_above, cal_active, cal_done, cal_error} = '0;
        meas_value = '0;
        cj_celsius = '0;
        system_time = '0;
        ce = 1'b1;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        rd(A_CTRL, 32'h0);
        rd(12'h114, 32'h8000_0000);
        rd(12'h118, 32'h7fff_ffff);
        rd(12'hffc, 32'h0);
        chk("pslverr", {31'h0, e}, 32'h1);
        meas_below <= 4'h2;
        smp(32'h0);
        chk("fault word", {28'h0, chan_fault_word}, 32'h2);
        chk("any faults", {30'h0, any_chan_fault, any_input_fault}, 32'h3);
        rd(12'h140, 32'h2);
        rd(A_CHAN_FAULT, 32'h2);
        comm_lost <= 1'b1;
        @(posedge core_clk);
        chk("copy", {28'h0, fault_copy}, 32'hf);
        comm_lost <= 1'b0;
        meas_below <= 4'h0;
        meas_above <= 4'h4;
        smp(32'h0);
        rd(12'h180, 32'h4);
        chk("fault word", {28'h0, chan_fault_word}, 32'h4);
        meas_above <= 4'h0;
        cal_active <= 4'h8;
        smp(32'h0);
        chk("cal", {27'h0, calibrating, chan_fault_word}, 32'h18);
        cal_active <= 4'h0;
        cal_done <= 4'h8;
        cal_error <= 4'h8;
        @(posedge core_clk);
        cal_done <= 4'h0;
        repeat (2) @(posedge core_clk);
        chk("bad cal", {31'h0, any_bad_cal}, 32'h1);
        rd(12'h1c0, 32'h1);
        rd(A_MOD_FAULT, 32'h8);
        acc(1'b1, A_CTRL, 32'h1);
        cj_celsius <= 32'h0064_0000;
        smp(32'h0);
        rd(A_CJ_TEMP, 32'h00d4_0000);
        chk("cj", {30'h0, cold_junc_high, cold_junc_low}, 32'h2);
        rd(A_MOD_FAULT, 32'h28);
        cj_celsius <= CJ_MAX_C;
        smp(32'h0);
        chk("cj", {30'h0, cold_junc_high, cold_junc_low}, 32'h0);
        cj_celsius <= 32'hffff_0000;
        smp(32'h0);
        chk("cj", {30'h0, cold_junc_high, cold_junc_low}, 32'h1);
        acc(1'b1, 12'h10c, 32'h5_0000);
        smp(32'ha_0000);
        rd(12'h100, 32'h8);
        smp(32'ha_0000);
        rd(12'h100, 32'h0);
        acc(1'b1, 12'h108, 32'h1);
        smp(32'h14_0000);
        smp(32'h14_0000);
        rd(12'h100, 32'h8);
        acc(1'b1, 12'h124, 32'h8);
        rd(12'h100, 32'h0);
        acc(1'b1, 12'h108, 32'h0);
        system_time <= 64'h0123_4567_89ab_cdef;
        for (int i = 0; i < 6; i++) begin
            acc(1'b1, ta[i], tv[i]);
        end
        for (int i = 0; i < 8; i++) begin
            smp(pv[i] << 16);
            rd(12'h100, ps[i]);
            rd(12'h104, pv[i] << 16);
        end
        acc(1'b1, 12'h108, 32'h2);
        smp(32'h4_0000);
        smp(32'hf_0000);
        rd(12'h100, 32'hf0);
        acc(1'b1, 12'h124, 32'hf8);
        rd(12'h100, 32'h0);
        rd(A_SYS_HI, 32'h0);
        acc(1'b1, A_CTRL, 32'h2);
        system_time <= 64'h0123_4567_89ab_cdef;
        smp(32'hf_0000);
        acc(1'b0, A_LOCAL_MS, 32'h0);
        t0 = q;
        repeat (93) @(posedge core_clk);
        smp(32'hf_0000);
        rd(A_SYS_LO, 32'h89ab_cdef);
        rd(A_SYS_HI, 32'h0123_4567);
        rd(A_LOCAL_MS, {16'h0, t0[15:0] + 16'd10});
        rd(A_CJ_TEMP, 32'hffff_0000);
        ce <= 1'b0;
        smp(32'h1_0000);
        ce <= 1'b1;
        rd(12'h104, 32'hf_0000);
        rd(A_LOCAL_MS, {16'h0, t0[15:0] + 16'd10});
        report_and_stop();
    end
endmodule : aisa_top_tb
